/* rtl/sflash_pkg.sv */
// Constants, types and state encodings of the serial flash command front end.
// What this block does
// - All instruction, address and data bytes move most significant bit first.
// - Status register reads refetch the same register for each byte until chip select rises.
// - Program bytes past 256 wrap to the page start and overwrite.
// - Security registers: upper byte 00h, middle byte 10h/20h/30h, low byte offset.
// - Dual address: line one odd bits, line zero even bits, top first.
// - Dual output: line one bits 7,5,3,1, line zero bits 6,4,2,0.
// - Quad address: line three high bit of each nibble; 24 address then 8 mode.
// - Quad data: upper nibble first, line three is each nibble's top bit.
// - Quad I/O read EBh: four dummy clocks after mode bits, then data.
// - Code 06h sets the write enable latch.
// - Code 50h keeps the latch and arms a volatile status write.
// - Code 04h clears the write enable latch.
// - Latch clears at reset and when any write, program or erase completes.
// - Code 04h also cancels a pending volatile status write arming.
// - After 05h or 35h, status one or two shifts out on falling edges.
// - Status reads are accepted at any time, busy included.
// - Quad output and quad I/O reads need the quad enable bit set.
// - Busy reads one during a self-timed status write, zero after.
package sflash_pkg;
	// ----------------------------------------------------------------
	// Instruction codes
	// ----------------------------------------------------------------
	localparam logic [7:0] OP_WREN = 8'h06;
	localparam logic [7:0] OP_VWREN = 8'h50;
	localparam logic [7:0] OP_WRDIS = 8'h04;
	localparam logic [7:0] OP_RDSR1 = 8'h05;
	localparam logic [7:0] OP_RDSR2 = 8'h35;
	localparam logic [7:0] OP_WRSR = 8'h01;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_FREAD = 8'h0b;
	localparam logic [7:0] OP_DOUT = 8'h3b;
	localparam logic [7:0] OP_QOUT = 8'h6b;
	localparam logic [7:0] OP_DIO = 8'hbb;
	localparam logic [7:0] OP_QIO = 8'heb;
	localparam logic [7:0] OP_WRAP = 8'h77;
	localparam logic [7:0] OP_PP = 8'h02;
	localparam logic [7:0] OP_QPP = 8'h32;
	localparam logic [7:0] OP_SE = 8'h20;
	localparam logic [7:0] OP_BE32 = 8'h52;
	localparam logic [7:0] OP_BE64 = 8'hd8;
	localparam logic [7:0] OP_CE1 = 8'hc7;
	localparam logic [7:0] OP_CE2 = 8'h60;
	localparam logic [7:0] OP_SECER = 8'h44;
	localparam logic [7:0] OP_SECPP = 8'h42;
	localparam logic [7:0] OP_SECRD = 8'h48;
	// ----------------------------------------------------------------
	// Status bits and write masks
	// ----------------------------------------------------------------
	localparam int SR1_BUSY = 0;
	localparam int SR1_WEL = 1;
	localparam int SR2_SRP1 = 0;
	localparam int SR2_QE = 1;
	localparam logic [7:0] SR1_WR_MASK = 8'hfc;
	localparam logic [7:0] SR2_WR_MASK = 8'h7f;
	localparam logic [7:0] SR2_SHORT_CLR = 8'h43;
	localparam logic [7:0] SR2_OTP_MASK = 8'h39;
	localparam logic [7:0] SR_RESET = 8'h00;
	// ----------------------------------------------------------------
	// Framing
	// ----------------------------------------------------------------
	localparam logic [2:0] LANE1 = 3'h1;
	localparam logic [2:0] LANE2 = 3'h2;
	localparam logic [2:0] LANE4 = 3'h4;
	localparam logic [5:0] OPC_BITS = 6'h08;
	localparam logic [5:0] ADDR_BITS = 6'h18;
	localparam logic [5:0] ADDR_MODE_BITS = 6'h20;
	localparam logic [5:0] SR_SHORT = 6'h08;
	localparam logic [5:0] SR_LONG = 6'h10;
	localparam logic [3:0] DUMMY_FAST = 4'h8;
	localparam logic [3:0] DUMMY_QIO = 4'h4;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [5:0] WRAP_CLK = 6'h06;
	localparam logic [7:0] SEC_HI = 8'h00;
	localparam logic [7:0] SEC_R1 = 8'h10;
	localparam logic [7:0] SEC_R2 = 8'h20;
	localparam logic [7:0] SEC_R3 = 8'h30;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_NS = 8;
	localparam int TW_NS = 10000;
	localparam int TW_CYCLES = (TW_NS + CLK_NS - 1) / CLK_NS;
	localparam int FIFO_DEPTH = 8;
	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [23:0] addr;
		logic [7:0] data;
	} prog_word_t;
	typedef enum logic [8:0] {
		PH_IDLE = 9'h001,
		PH_OPC = 9'h002,
		PH_ADDR = 9'h004,
		PH_DUMMY = 9'h008,
		PH_DOUT = 9'h010,
		PH_DIN = 9'h020,
		PH_SRIN = 9'h040,
		PH_WRAP = 9'h080,
		PH_DONE = 9'h100
	} phase_t;
endpackage

/* rtl/sflash_front.sv */
// Serial flash command front end: pin sampling, decode, status, write latch.

// ----------------------------------------------------------------
// Program data FIFO
// ----------------------------------------------------------------
module sflash_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	// Fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	// Drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0] cnt;
	} fifo_t;
	fifo_t s;
	fifo_t next_s;
	logic push;
	logic pop;

	assign in_ready_o = (s.cnt != (AW+1)'(DEPTH));
	assign out_valid_o = (s.cnt != '0);
	assign out_data_o = s.mem[s.rd];
	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;

	always_comb begin
		next_s = s;
		if (push) begin
			next_s.mem[s.wr] = in_data_i;
			next_s.wr = (s.wr == AW'(DEPTH - 1)) ? '0 : s.wr + 1'b1;
		end
		if (pop) begin
			next_s.rd = (s.rd == AW'(DEPTH - 1)) ? '0 : s.rd + 1'b1;
		end
		next_s.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
endmodule // sflash_fifo

// ----------------------------------------------------------------
// Command front end
// ----------------------------------------------------------------
module sflash_front
	import sflash_pkg::*;
#(
	parameter int BUSY_CYCLES = sflash_pkg::TW_CYCLES,
	parameter int DEPTH = sflash_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// Serial link pins
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic [3:0] io_i,
	output logic [3:0] io_o,
	output logic [3:0] io_oe_o,
	// Array read port
	output logic [23:0] rd_addr_o,
	input wire logic [7:0] rd_data_i,
	// Program data stream
	output logic prog_valid_o,
	output sflash_pkg::prog_word_t prog_word_o,
	input wire logic prog_ready_i,
	output logic overrun_o,
	// Operation start and status
	output logic op_start_o,
	output logic [7:0] op_code_o,
	output logic [23:0] op_addr_o,
	output logic [1:0] sec_sel_o,
	output logic [7:0] status1_o,
	output logic [7:0] status2_o,
	output logic [2:0] wrap_length_bits_o
);
	import sflash_pkg::*;

	typedef struct packed {
		logic [2:0] sclk_s;
		logic [2:0] cs_s;
		logic [3:0] io_s0;
		logic [3:0] io_s1;
		phase_t phase;
		logic [7:0] opc;
		logic [31:0] sh;
		logic [5:0] cnt;
		logic [5:0] alen;
		logic [2:0] lanes;
		logic [3:0] dummy;
		logic [3:0] obit;
		logic [7:0] obyte;
		logic [23:0] addr;
		logic got_byte;
		logic write_enable_latch;
		logic varm;
		logic [7:0] sr1;
		logic [7:0] sr2;
		logic busy;
		logic [15:0] btimer;
		logic pend_sr;
		logic pend_long;
		logic [15:0] pend_val;
		logic push;
		prog_word_t push_word;
		logic overrun;
		logic op_start;
		logic [7:0] op_code;
		logic [23:0] op_addr;
		logic [1:0] sec_sel;
		logic [23:0] rd_addr;
		logic [3:0] io_out;
		logic [3:0] io_oe;
		logic [2:0] wrap_length_bits;
	} state_t;

	state_t s;
	state_t next_s;
	logic fifo_ready;
	logic fifo_valid;
	logic rise;
	logic fall;
	logic cs_high;
	logic cs_rise;
	logic [31:0] shifted;
	logic [7:0] stat1;
	logic [7:0] fresh;
	logic [7:0] cur;
	logic [5:0] ncnt;

	function automatic logic [3:0] lane_bits(input logic [3:0] io, input logic [2:0] lanes);
		logic [3:0] r;
		r = '0;
		case (lanes)
			LANE2: r = {2'h0, io[1:0]};
			LANE4: r = io;
			default: r = {3'h0, io[0]};
		endcase
		return r;
	endfunction

	function automatic logic [1:0] sec_of(input logic [23:0] a);
		logic [1:0] r;
		r = 2'h0;
		if (a[23:16] == SEC_HI) begin
			if (a[15:8] == SEC_R1) r = 2'h1;
			else if (a[15:8] == SEC_R2) r = 2'h2;
			else if (a[15:8] == SEC_R3) r = 2'h3;
		end
		return r;
	endfunction

	// ----------------------------------------------------------------
	// Pin edges, all read from the second synchroniser stage onward
	// ----------------------------------------------------------------
	assign rise = s.sclk_s[1] & ~s.sclk_s[2];
	assign fall = ~s.sclk_s[1] & s.sclk_s[2];
	assign cs_high = s.cs_s[1];
	assign cs_rise = s.cs_s[1] & ~s.cs_s[2];
	assign shifted = (s.sh << s.lanes) | {28'h0, lane_bits(s.io_s1, s.lanes)};
	assign ncnt = s.cnt + {3'h0, s.lanes};
	assign stat1 = {s.sr1[7:2], s.write_enable_latch, s.busy};
	assign fresh = (s.opc == OP_RDSR1) ? stat1 : (s.opc == OP_RDSR2) ? s.sr2 : rd_data_i;
	assign cur = (s.obit == '0) ? fresh : s.obyte;

	always_comb begin
		next_s = s;
		next_s.sclk_s = {s.sclk_s[1:0], sclk_i};
		next_s.cs_s = {s.cs_s[1:0], cs_n_i};
		next_s.io_s0 = io_i;
		next_s.io_s1 = s.io_s0;
		next_s.push = 1'b0;
		next_s.op_start = 1'b0;
		if (s.push && !fifo_ready) begin
			next_s.overrun = 1'b1;
		end

		// ------------------------------------------------------------
		// Self-timed cycle; ends only once the program data has drained
		// ------------------------------------------------------------
		if (s.busy) begin
			if (s.btimer != '0) begin
				next_s.btimer = s.btimer - 16'h1;
			end else if (!fifo_valid && !s.push) begin
				next_s.busy = 1'b0;
				next_s.write_enable_latch = 1'b0;
				next_s.pend_sr = 1'b0;
				if (s.pend_sr) begin
					next_s.sr1 = s.pend_val[7:0] & SR1_WR_MASK;
					next_s.sr2 = s.pend_long ? ((s.pend_val[15:8] & SR2_WR_MASK)
						| (s.sr2 & SR2_OTP_MASK)) : (s.sr2 & ~SR2_SHORT_CLR);
				end
			end
		end

		// ------------------------------------------------------------
		// Frame end: commit what the frame asked for
		// ------------------------------------------------------------
		if (cs_high) begin
			next_s.phase = PH_IDLE;
			next_s.io_oe = '0;
			if (cs_rise) begin
				case (s.phase)
					PH_DONE: begin
						if (s.opc == OP_WREN) begin
							next_s.write_enable_latch = 1'b1;
						end else if (s.opc == OP_WRDIS) begin
							next_s.write_enable_latch = 1'b0;
							next_s.varm = 1'b0;
						end else if (s.opc == OP_VWREN) begin
							next_s.varm = 1'b1;
						end else if (s.write_enable_latch && !s.busy && (s.opc inside {OP_SE,
							OP_BE32, OP_BE64, OP_SECER, OP_CE1, OP_CE2})) begin
							next_s.busy = 1'b1;
							next_s.btimer = 16'(BUSY_CYCLES - 1);
							next_s.op_start = 1'b1;
							next_s.op_code = s.opc;
							next_s.op_addr = s.addr;
						end
					end
					PH_DIN: begin
						if (s.write_enable_latch && !s.busy && s.got_byte) begin
							next_s.busy = 1'b1;
							next_s.btimer = 16'(BUSY_CYCLES - 1);
							next_s.op_start = 1'b1;
							next_s.op_code = s.opc;
							next_s.op_addr = s.addr;
						end
					end
					PH_SRIN: begin
						if (!s.busy && (s.cnt == SR_SHORT || s.cnt == SR_LONG)) begin
							if (s.write_enable_latch) begin
								next_s.busy = 1'b1;
								next_s.btimer = 16'(BUSY_CYCLES - 1);
								next_s.pend_sr = 1'b1;
								next_s.pend_long = (s.cnt == SR_LONG);
								// First byte on the wire is status one; keep it in the low half
								next_s.pend_val = (s.cnt == SR_LONG) ? {s.sh[7:0], s.sh[15:8]}
									: {8'h00, s.sh[7:0]};
							end else if (s.varm) begin
								next_s.varm = 1'b0;
								next_s.sr1 = (s.cnt == SR_LONG ? s.sh[15:8] : s.sh[7:0])
									& SR1_WR_MASK;
								next_s.sr2 = (s.cnt == SR_LONG) ? ((s.sh[7:0] & SR2_WR_MASK)
									| (s.sr2 & SR2_OTP_MASK)) : (s.sr2 & ~SR2_SHORT_CLR);
							end
						end
					end
					default: begin
						// Short opcode or foreign frame: nothing changes
						next_s.phase = PH_IDLE;
					end
				endcase
			end
		end else if (s.phase == PH_IDLE) begin
			next_s.phase = PH_OPC;
			next_s.cnt = '0;
			next_s.lanes = LANE1;
			next_s.got_byte = 1'b0;
			next_s.obit = '0;
		end else if (rise) begin
			// --------------------------------------------------------
			// Rising edges: sample inputs
			// --------------------------------------------------------
			next_s.sh = shifted;
			next_s.cnt = ncnt;
			case (s.phase)
				PH_OPC: begin
					if (ncnt == OPC_BITS) begin
						next_s.opc = shifted[7:0];
						next_s.cnt = '0;
						next_s.alen = ADDR_BITS;
						next_s.dummy = '0;
						case (shifted[7:0])
							OP_WREN, OP_WRDIS, OP_VWREN, OP_CE1, OP_CE2: next_s.phase = PH_DONE;
							OP_RDSR1, OP_RDSR2: next_s.phase = PH_DOUT;
							OP_WRSR: next_s.phase = PH_SRIN;
							OP_PP, OP_QPP, OP_SECPP, OP_SE, OP_BE32, OP_BE64, OP_SECER:
								next_s.phase = PH_ADDR;
							OP_READ: next_s.phase = s.busy ? PH_DONE : PH_ADDR;
							OP_FREAD, OP_DOUT, OP_SECRD: begin
								next_s.phase = s.busy ? PH_DONE : PH_ADDR;
								next_s.dummy = DUMMY_FAST;
							end
							OP_QOUT: begin
								next_s.phase = (s.busy || !s.sr2[SR2_QE]) ? PH_DONE : PH_ADDR;
								next_s.dummy = DUMMY_FAST;
							end
							OP_DIO: begin
								next_s.phase = s.busy ? PH_DONE : PH_ADDR;
								next_s.lanes = LANE2;
								next_s.alen = ADDR_MODE_BITS;
							end
							OP_QIO: begin
								next_s.phase = (s.busy || !s.sr2[SR2_QE]) ? PH_DONE : PH_ADDR;
								next_s.lanes = LANE4;
								next_s.alen = ADDR_MODE_BITS;
								next_s.dummy = DUMMY_QIO;
							end
							OP_WRAP: begin
								next_s.phase = PH_WRAP;
								next_s.lanes = LANE4;
							end
							default: next_s.phase = PH_DONE;
						endcase
						// Foreign codes must not commit anything at frame end
						if (next_s.phase == PH_DONE && !(shifted[7:0] inside {OP_WREN,
							OP_WRDIS, OP_VWREN, OP_CE1, OP_CE2})) begin
							next_s.opc = OP_READ;
						end
					end
				end
				PH_ADDR: begin
					if (ncnt == s.alen) begin
						next_s.cnt = '0;
						next_s.addr = (s.alen == ADDR_MODE_BITS) ? shifted[31:8] : shifted[23:0];
						next_s.sec_sel = sec_of(next_s.addr);
						next_s.rd_addr = next_s.addr;
						case (s.opc)
							OP_SE, OP_BE32, OP_BE64, OP_SECER: next_s.phase = PH_DONE;
							OP_PP, OP_SECPP: next_s.phase = PH_DIN;
							OP_QPP: begin
								next_s.phase = PH_DIN;
								next_s.lanes = LANE4;
							end
							default: next_s.phase = (s.dummy == '0) ? PH_DOUT : PH_DUMMY;
						endcase
					end
				end
				PH_DUMMY: begin
					next_s.dummy = s.dummy - 4'h1;
					if (s.dummy == 4'h1) begin
						next_s.phase = PH_DOUT;
					end
				end
				PH_DIN: begin
					if (ncnt == 6'(BYTE_BITS)) begin
						next_s.cnt = '0;
						next_s.got_byte = 1'b1;
						if (s.write_enable_latch && !s.busy) begin
							next_s.push = 1'b1;
							next_s.push_word = '{addr: s.rd_addr, data: shifted[7:0]};
						end
						// Low address byte wraps inside the page
						next_s.rd_addr = {s.rd_addr[23:8], s.rd_addr[7:0] + 8'h01};
					end
				end
				PH_WRAP: begin
					// Counter moves four bits per quad clock, so the clock index is scaled
					if (s.cnt == {WRAP_CLK[3:0], 2'h0}) begin
						next_s.wrap_length_bits = s.io_s1[2:0];
					end
				end
				PH_SRIN: begin
					// Stop counting past the long form so a 17th bit voids the write
					next_s.cnt = (s.cnt > SR_LONG) ? s.cnt : ncnt;
				end
				default: begin
					next_s.cnt = s.cnt;
				end
			endcase
		end else if (fall && s.phase == PH_DOUT) begin
			// --------------------------------------------------------
			// Falling edges: drive output bits, top of byte first
			// --------------------------------------------------------
			if (s.obit == '0 && !(s.opc inside {OP_RDSR1, OP_RDSR2})) begin
				next_s.rd_addr = s.rd_addr + 24'h1;
			end
			case (s.opc)
				OP_DOUT, OP_DIO: begin
					next_s.io_out = {2'h0, cur[7:6]};
					next_s.io_oe = 4'h3;
					next_s.obyte = {cur[5:0], 2'h0};
					next_s.obit = ((s.obit == '0) ? BYTE_BITS : s.obit) - 4'h2;
				end
				OP_QOUT, OP_QIO: begin
					next_s.io_out = cur[7:4];
					next_s.io_oe = 4'hf;
					next_s.obyte = {cur[3:0], 4'h0};
					next_s.obit = ((s.obit == '0) ? BYTE_BITS : s.obit) - 4'h4;
				end
				default: begin
					// Status bytes are refetched each time so busy stays live
					next_s.io_out = {2'h0, cur[7], 1'b0};
					next_s.io_oe = 4'h2;
					next_s.obyte = {cur[6:0], 1'b0};
					next_s.obit = ((s.obit == '0) ? BYTE_BITS : s.obit) - 4'h1;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			s <= '0;
			s.sclk_s <= 3'h0;
			s.cs_s <= 3'h7;
			s.phase <= PH_IDLE;
			s.lanes <= LANE1;
			s.sr1 <= SR_RESET;
			s.sr2 <= SR_RESET;
			s.write_enable_latch <= 1'b0;
		end else begin
			s <= next_s;
		end
	end

	sflash_fifo #(
		.WIDTH($bits(prog_word_t)),
		.DEPTH(DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.in_valid_i(s.push),
		.in_ready_o(fifo_ready),
		.in_data_i(s.push_word),
		.out_valid_o(fifo_valid),
		.out_ready_i(prog_ready_i),
		.out_data_o(prog_word_o)
	);

	assign prog_valid_o = fifo_valid;
	assign io_o = s.io_out;
	assign io_oe_o = s.io_oe;
	assign rd_addr_o = s.rd_addr;
	assign overrun_o = s.overrun;
	assign op_start_o = s.op_start;
	assign op_code_o = s.op_code;
	assign op_addr_o = s.op_addr;
	assign sec_sel_o = s.sec_sel;
	assign status1_o = stat1;
	assign status2_o = s.sr2;
	assign wrap_length_bits_o = s.wrap_length_bits;
endmodule // sflash_front

/* tb/sflash_front_asserts.sv */
// Port-level assertions for the serial flash command front end.
module sflash_front_asserts
	import sflash_pkg::*;
#(
	parameter int BUSY_CYCLES = 8,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// Observed ports
	input wire logic cs_n_i,
	input wire logic [3:0] io_oe_o,
	input wire logic prog_valid_o,
	input wire logic op_start_o,
	input wire logic [7:0] status1_o,
	input wire logic [7:0] status2_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] high_cnt;
	// Cycles of chip select held high, saturating
	always_ff @(posedge clk_i) begin
		if (!nrst_i || !cs_n_i) begin
			high_cnt <= 4'h0;
		end else if (high_cnt != 4'hf) begin
			high_cnt <= high_cnt + 4'h1;
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	sequence s_busy_run;
		status1_o[SR1_BUSY] [*4];
	endsequence
	property p_start_busy;
		op_start_o |-> ##[0:2] s_busy_run;
	endproperty
	a_start_busy: assert property (p_start_busy)
		else $error("busy did not follow an accepted operation");
	property p_start_wel;
		op_start_o |-> status1_o[SR1_WEL];
	endproperty
	a_start_wel: assert property (p_start_wel)
		else $error("operation started with the latch clear");
	property p_wel_rise;
		$rose(status1_o[SR1_WEL]) |-> cs_n_i;
	endproperty
	a_wel_rise: assert property (p_wel_rise)
		else $error("latch set inside a frame");
	property p_busy_end;
		$fell(status1_o[SR1_BUSY]) |-> ##[0:1] (!status1_o[SR1_WEL] && !prog_valid_o);
	endproperty
	a_busy_end: assert property (p_busy_end)
		else $error("latch or buffer left over after busy");
	property p_oe_idle;
		high_cnt >= 4'h6 |-> io_oe_o == 4'h0;
	endproperty
	a_oe_idle: assert property (p_oe_idle)
		else $error("lines driven with chip select high");
	property p_oe_form;
		io_oe_o inside {4'h0, 4'h2, 4'h3, 4'hf};
	endproperty
	a_oe_form: assert property (p_oe_form)
		else $error("illegal line enable pattern");
	property p_quad_qe;
		io_oe_o == 4'hf |-> status2_o[SR2_QE];
	endproperty
	a_quad_qe: assert property (p_quad_qe)
		else $error("quad output with quad enable clear");
	property p_oe_start;
		$rose(|io_oe_o) |-> !cs_n_i;
	endproperty
	a_oe_start: assert property (p_oe_start)
		else $error("output started outside a frame");
endmodule // sflash_front_asserts

bind sflash_front sflash_front_asserts #(
	.BUSY_CYCLES(BUSY_CYCLES),
	.DEPTH(DEPTH)
) i_sflash_front_asserts (
	.clk_i(clk_i), .nrst_i(nrst_i), .cs_n_i(cs_n_i), .io_oe_o(io_oe_o),
	.prog_valid_o(prog_valid_o), .op_start_o(op_start_o),
	.status1_o(status1_o), .status2_o(status2_o)
);

/* tb/spi_host.sv */
// Host controller model driving the serial clock, chip select and data lines.
module spi_host (
	// Clock
	input wire logic clk_i,
	// Device side of the lines
	input wire logic [3:0] dev_io_i,
	input wire logic [3:0] dev_oe_i,
	// Link
	output logic sclk_o,
	output logic cs_n_o,
	output logic [3:0] io_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] drv;
	logic [3:0] en;
	logic [3:0] last;
	// Released lines flip every cycle so a stale level can never pass
	assign io_o = (dev_oe_i & dev_io_i) | (~dev_oe_i & en & drv) | (~dev_oe_i & ~en & ~last);
	always @(posedge clk_i) last <= io_o;
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		drv = 4'h0;
		en = 4'h0;
		last = 4'h0;
	end
	task automatic half();
		repeat (10) @(posedge clk_i);
		#1;
	endtask
	task automatic frame_on();
		half();
		cs_n_o = 1'b0;
	endtask
	task automatic close();
		half();
		cs_n_o = 1'b1;
		en = 4'h0;
		half();
	endtask
	// Width 1 drives line 0 and reads line 1; 2 uses lines 1..0; 4 uses 3..0
	task automatic shift(input logic [31:0] v, input int n, input int w, input bit out,
		output logic [31:0] rv);
		logic [3:0] m;
		m = (w == 1) ? 4'h1 : (w == 2) ? 4'h3 : 4'hf;
		rv = '0;
		for (int i = n - w; i >= 0; i -= w) begin
			drv = 4'(v >> i) & m;
			en = out ? m : 4'h0;
			half();
			sclk_o = 1'b1;
			rv = (rv << w) | ((w == 1) ? 32'(io_o[1]) : 32'(io_o & m));
			half();
			sclk_o = 1'b0;
		end
	endtask
endmodule // spi_host

/* tb/tb_sflash_front.sv */
// Self-checking bench for the serial flash command front end.
module tb_sflash_front;
	timeunit 1ns;
	timeprecision 100ps;
	import sflash_pkg::*;
	logic clk_i, nrst_i, prog_ready_i, sclk, cs_n, overrun, op_start, prog_valid;
	logic [3:0] io, dev_io, dev_oe;
	logic [7:0] rd_data, op_code, sr1, sr2;
	logic [23:0] rd_addr, op_addr;
	logic [1:0] sec_sel;
	logic [2:0] wrap_bits;
	prog_word_t word;
	prog_word_t got[$];
	logic [31:0] rv;
	int err_count = 0;
	int check_count = 0;
	int cyc = 0;

	sflash_front #(.BUSY_CYCLES(1000), .DEPTH(8)) i_sflash_front (
		.clk_i(clk_i), .nrst_i(nrst_i), .sclk_i(sclk), .cs_n_i(cs_n), .io_i(io),
		.io_o(dev_io), .io_oe_o(dev_oe), .rd_addr_o(rd_addr), .rd_data_i(rd_data),
		.prog_valid_o(prog_valid), .prog_word_o(word), .prog_ready_i(prog_ready_i),
		.overrun_o(overrun), .op_start_o(op_start), .op_code_o(op_code),
		.op_addr_o(op_addr), .sec_sel_o(sec_sel), .status1_o(sr1), .status2_o(sr2),
		.wrap_length_bits_o(wrap_bits)
	);
	spi_host host (
		.clk_i(clk_i), .dev_io_i(dev_io), .dev_oe_i(dev_oe), .sclk_o(sclk),
		.cs_n_o(cs_n), .io_o(io)
	);

	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	// Array stand-in: each byte is its low address bits with a fixed pattern
	always @(posedge clk_i) rd_data <= rd_addr[7:0] ^ 8'h5a;
	always @(posedge clk_i) if (nrst_i && prog_valid && prog_ready_i) got.push_back(word);
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 60000) begin
			err_count++;
			wrap_up();
		end
	end

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
		check_count++;
		if (exp !== seen) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic cmd(input logic [7:0] op);
		host.frame_on();
		host.shift(32'(op), 8, 1, 1'b1, rv);
	endtask
	task automatic op1(input logic [7:0] op);
		cmd(op);
		host.close();
	endtask
	task automatic rd_sr(input logic [7:0] op, input logic [7:0] exp);
		cmd(op);
		host.shift(32'h0, 16, 1, 1'b0, rv);
		host.close();
		check("status", {16'h0, exp, exp}, {16'h0, rv[15:0]});
	endtask
	task automatic wr_sr(input logic [15:0] v);
		cmd(OP_WRSR);
		host.shift(32'(v), 16, 1, 1'b1, rv);
		host.close();
	endtask
	task automatic wait_idle();
		for (int i = 0; i < 3000 && sr1[SR1_BUSY] !== 1'b0; i++) @(posedge clk_i);
		#1;
	endtask

	task automatic t_latch();
		host.frame_on();
		host.shift(32'h3, 7, 1, 1'b1, rv);
		host.close();
		rd_sr(OP_RDSR1, 8'h00);
		op1(OP_WREN);
		rd_sr(OP_RDSR1, 8'h02);
		cmd(OP_QOUT);
		host.shift(32'h0, 32, 1, 1'b1, rv);
		host.close();
		rd_sr(OP_RDSR1, 8'h02);
		op1(OP_WRDIS);
		rd_sr(OP_RDSR1, 8'h00);
		$display("test latch done");
	endtask
	task automatic t_status();
		wr_sr(16'h0002);
		rd_sr(OP_RDSR2, 8'h00);
		op1(OP_WREN);
		wr_sr(16'h0002);
		rd_sr(OP_RDSR1, 8'h03);
		wait_idle();
		rd_sr(OP_RDSR1, 8'h00);
		rd_sr(OP_RDSR2, 8'h02);
		$display("test status write done");
	endtask
	task automatic t_volatile();
		op1(OP_VWREN);
		rd_sr(OP_RDSR1, 8'h00);
		op1(OP_WRDIS);
		wr_sr(16'h2000);
		rd_sr(OP_RDSR1, 8'h00);
		op1(OP_VWREN);
		wr_sr(16'h2002);
		rd_sr(OP_RDSR1, 8'h20);
		$display("test volatile write done");
	endtask
	task automatic t_page();
		got.delete();
		op1(OP_WREN);
		cmd(OP_QPP);
		host.shift(32'h034500, 24, 1, 1'b1, rv);
		for (int k = 0; k < 257; k++) host.shift(32'(k[7:0] ^ 8'h3c), 8, 4, 1'b1, rv);
		host.close();
		check("op code", 32'(OP_QPP), 32'(op_code));
		check("op address", 32'h034500, 32'(op_addr));
		wait_idle();
		check("word count", 257, got.size());
		for (int k = 0; k < 257; k++) check("word", {16'h0345, k[7:0], k[7:0] ^ 8'h3c}, got[k]);
		rd_sr(OP_RDSR1, 8'h20);
		$display("test quad page done");
	endtask
	task automatic t_fifo();
		got.delete();
		prog_ready_i = 1'b0;
		op1(OP_WREN);
		cmd(OP_SECPP);
		host.shift(32'h002007, 24, 1, 1'b1, rv);
		for (int k = 0; k < 9; k++) host.shift(32'(8'hc0 + k), 8, 1, 1'b1, rv);
		host.close();
		check("security select", 32'h2, 32'(sec_sel));
		check("overrun", 32'h1, 32'(overrun));
		check("head valid", 32'h1, 32'(prog_valid));
		prog_ready_i = 1'b1;
		wait_idle();
		check("drained", 32'h0, 32'(prog_valid));
		check("word count", 8, got.size());
		check("first word", 32'h002007c0, got[0]);
		check("last word", 32'h00200ec7, got[7]);
		$display("test buffer done");
	endtask
	task automatic t_reads();
		cmd(OP_QIO);
		host.shift(32'h0000c4ff, 32, 4, 1'b1, rv);
		host.shift(32'h0, 16, 4, 1'b0, rv);
		host.shift(32'h0, 16, 4, 1'b0, rv);
		host.close();
		check("quad io read", {8'hc4 ^ 8'h5a, 8'hc5 ^ 8'h5a}, rv);
		cmd(OP_DOUT);
		host.shift(32'h000010, 24, 1, 1'b1, rv);
		host.shift(32'h0, 8, 1, 1'b0, rv);
		host.shift(32'h0, 16, 2, 1'b0, rv);
		host.close();
		check("dual read", {8'h10 ^ 8'h5a, 8'h11 ^ 8'h5a}, rv);
		cmd(OP_DIO);
		host.shift(32'h000020ff, 32, 2, 1'b1, rv);
		host.shift(32'h0, 8, 2, 1'b0, rv);
		host.close();
		check("dual io read", 32'(8'h20 ^ 8'h5a), rv);
		cmd(OP_QOUT);
		host.shift(32'h000030, 24, 1, 1'b1, rv);
		host.shift(32'h0, 8, 1, 1'b0, rv);
		host.shift(32'h0, 8, 4, 1'b0, rv);
		host.close();
		check("quad out read", 32'(8'h30 ^ 8'h5a), rv);
		cmd(OP_WRAP);
		host.shift(32'h00000050, 32, 4, 1'b1, rv);
		host.close();
		check("wrap bits", 32'h5, 32'(wrap_bits));
		$display("test reads done");
	endtask

	initial begin
		nrst_i = 1'b0;
		prog_ready_i = 1'b1;
		rd_data = 8'h00;
		repeat (6) @(posedge clk_i);
		#1;
		nrst_i = 1'b1;
		repeat (4) @(posedge clk_i);
		t_latch();
		t_status();
		t_volatile();
		t_page();
		t_fifo();
		t_reads();
		wrap_up();
	end
endmodule // tb_sflash_front
